// ==== rtl/tdcd_pkg.sv ====
// Package for the channel D control/status register set of the time measurement unit.
// Assumes a single 20 MHz clock and a parallel host register port with 8-bit word addresses.
package tdcd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int STAMP_W = 40;

  // Word addresses
  localparam logic [7:0] ADDR_CH_CTRL_MAIN = 8'h60;
  localparam logic [7:0] ADDR_CH_CTRL_ARM = 8'h61;
  localparam logic [7:0] ADDR_CH_STATUS = 8'h64;
  localparam logic [7:0] ADDR_CH_HOLDOFF = 8'h66;
  localparam logic [7:0] ADDR_CH_CAL_RR = 8'h6c;
  localparam logic [7:0] ADDR_CH_CAL_RF = 8'h6d;
  localparam logic [7:0] ADDR_CH_CAL_FR = 8'h6e;
  localparam logic [7:0] ADDR_CH_CAL_FF = 8'h6f;
  localparam logic [7:0] ADDR_CH_STAMP_LOW = 8'h70;
  localparam logic [7:0] ADDR_CH_STAMP_MID = 8'h71;
  localparam logic [7:0] ADDR_CH_STAMP_HIGH = 8'h72;
  localparam logic [7:0] ADDR_CENTRAL_CTRL_MAIN = 8'h80;
  localparam logic [7:0] ADDR_CENTRAL_CTRL_AUX = 8'h81;
  localparam logic [7:0] ADDR_CENTRAL_STATUS = 8'h82;
  localparam logic [7:0] ADDR_PART_ID = 8'h83;

  localparam logic [15:0] REG_RESET = 16'h0000;
  // Arbitrary neutral identification value
  localparam logic [15:0] PART_ID_DEFAULT = 16'h5a01;

  // Channel main control fields
  localparam int CH_POWER_BIT = 0;
  localparam int CH_GATE_BIT = 1;
  localparam int CH_POL_BIT = 2;
  localparam int CH_HOLDOFF_LSB = 7;
  localparam int CH_HOLDOFF_TIME_EN_BIT = 10;
  localparam int CH_PRECON_EN_BIT = 13;
  localparam logic [15:0] CH_CTRL_MAIN_WMASK = 16'h2787;
  // Channel arming control fields
  localparam int CH_ARM_SEL_LSB = 1;
  localparam int CH_ARM_EN_BIT = 5;
  localparam logic [15:0] CH_CTRL_ARM_WMASK = 16'h003e;
  // Channel status fields
  localparam int CH_ST_DLL_UNLOCK_BIT = 0;
  localparam int CH_ST_FULL_BIT = 3;
  localparam int CH_ST_EMPTY_BIT = 4;

  // Central control fields
  localparam int CEN_RESET_BIT = 1;
  localparam int CEN_DDR_BIT = 2;
  localparam int CEN_LENGTH_LSB = 5;
  localparam int CEN_RCLK_SEL_LSB = 8;
  localparam int CEN_OT_EN_BIT = 10;
  localparam int CEN_OT_CLR_BIT = 11;
  localparam int CEN_RCLK_EN_BIT = 15;
  localparam logic [15:0] CEN_CTRL_MAIN_WMASK = 16'hf7fd;
  localparam int CEN_CNT_RNG_LSB = 1;
  localparam int CEN_QUIET_BIT = 3;
  localparam logic [15:0] CEN_CTRL_AUX_WMASK = 16'h000e;
  // Central status fields
  localparam int CEN_ST_READY_BIT = 0;
  localparam int CEN_ST_OT_BIT = 1;
  localparam int CEN_ST_SYNC_UNLOCK_BIT = 2;
  localparam int CEN_ST_CLK_UNLOCK_BIT = 3;

  localparam int QUEUE_DEPTH = 16;
  localparam int QUIET_MAX_STAMPS = 16;

  localparam longint CLK_HZ = 20_000_000;
  localparam longint READY_SETTLE_US = 250;
  // Least time: round up to whole cycles
  localparam int READY_SETTLE_CYCLES = int'((READY_SETTLE_US * CLK_HZ + 999_999) / 1_000_000);

endpackage : tdcd_pkg

// ==== rtl/tdcd_stamp_queue.sv ====
// Time-stamp queue: fixed-depth first-in first-out store with flush.
// Assumes push and pop are single-cycle requests; a push while full is dropped.
`timescale 1ns/100ps
`default_nettype none
module tdcd_stamp_queue #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic o_full,
  output logic o_empty
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } tdcd_queue_state_t;

  tdcd_queue_state_t state_q;
  tdcd_queue_state_t state_d;
  logic push_ok;
  logic pop_ok;

  assign o_full = (state_q.count == CNT_W'(DEPTH));
  assign o_empty = (state_q.count == '0);
  assign o_head = state_q.mem[state_q.rd_ptr];
  assign push_ok = i_push && !o_full;
  assign pop_ok = i_pop && !o_empty;

  always_comb
  begin
    state_d = state_q;
    if (i_flush)
    begin
      state_d.wr_ptr = '0;
      state_d.rd_ptr = '0;
      state_d.count = '0;
    end
    else
    begin
      if (push_ok)
      begin
        state_d.mem[state_q.wr_ptr] = i_data;
        state_d.wr_ptr = (state_q.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_q.wr_ptr + 1'b1;
      end
      if (pop_ok)
      begin
        state_d.rd_ptr = (state_q.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_q.rd_ptr + 1'b1;
      end
      if (push_ok && !pop_ok)
      begin
        state_d.count = state_q.count + 1'b1;
      end
      else if (pop_ok && !push_ok)
      begin
        state_d.count = state_q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end
endmodule : tdcd_stamp_queue
`default_nettype wire

// ==== rtl/tdcd_ready_timer.sv ====
// Settling timer: counts a fixed number of cycles after reset or restart, then holds done.
// Assumes restart is a single-cycle pulse from the owning block.
`timescale 1ns/100ps
`default_nettype none
module tdcd_ready_timer #(
  parameter int SETTLE_CYCLES = 5000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  output logic o_done
);
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic done;
  } tdcd_timer_state_t;

  tdcd_timer_state_t state_q;
  tdcd_timer_state_t state_d;

  assign o_done = state_q.done;

  always_comb
  begin
    state_d = state_q;
    if (i_restart)
    begin
      state_d = '0;
    end
    else if (!state_q.done)
    begin
      if (state_q.count == CNT_W'(SETTLE_CYCLES - 1))
      begin
        state_d.done = 1'b1;
      end
      else
      begin
        state_d.count = state_q.count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end
endmodule : tdcd_ready_timer
`default_nettype wire

// ==== rtl/tdcd_regs.sv ====
// Channel D control/status registers, time-stamp capture and central control/status words.
// Assumes synchronous host register strobes and event/status inputs on the 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tdcd_regs #(
  parameter int READY_SETTLE_CYCLES = tdcd_pkg::READY_SETTLE_CYCLES,
  parameter int QUEUE_DEPTH = tdcd_pkg::QUEUE_DEPTH,
  parameter logic [15:0] PART_ID = tdcd_pkg::PART_ID_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [tdcd_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [tdcd_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_event,
  input wire logic [15:0] i_arm_conditions,
  input wire logic i_dll_locked,
  input wire logic i_sync_dll_locked,
  input wire logic i_core_clock_locked,
  input wire logic i_overheat,
  output logic [tdcd_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_channel_power_enable,
  output logic [2:0] o_holdoff_range_code,
  output logic o_precondition_enable,
  output logic o_ddr_mode,
  output logic o_result_clock_run,
  output logic [1:0] o_result_clock_rate_select,
  output logic [2:0] o_result_word_length_select,
  output logic [1:0] o_coarse_counter_range,
  output logic o_unit_ready_flag,
  output logic o_overheat_alarm_flag,
  output logic o_stamp_taken
);
  localparam int SW = tdcd_pkg::STAMP_W;

  typedef struct packed {
    logic [15:0] ctrl_main;
    logic [15:0] ctrl_arm;
    logic [15:0] holdoff_delay;
    logic [3:0][15:0] cal;
    logic [15:0] ch_status;
    logic [15:0] central_main;
    logic [15:0] central_aux;
    logic [15:0] central_status;
    logic [SW-1:0] snapshot;
    logic [SW-1:0] time_base;
    logic event_prev;
    logic [23:0] holdoff_count;
    logic [4:0] quiet_count;
    logic overheat;
    logic [15:0] rdata;
    logic rvalid;
    logic result_clock_run;
    logic stamp_taken;
  } tdcd_state_t;

  tdcd_state_t state_q;
  tdcd_state_t state_d;

  logic q_full;
  logic q_empty;
  logic [SW-1:0] q_head;
  logic q_push;
  logic q_pop;
  logic soft_reset;
  logic settled;

  logic wr_ch_main;
  logic wr_ch_arm;
  logic wr_cen_main;
  logic wr_cen_aux;
  logic edge_seen;
  logic armed;
  logic quiet;
  logic [3:0] arm_sel;
  logic [2:0] holdoff_code;
  logic accept;

  assign wr_ch_main = i_reg_wr && (i_reg_addr == tdcd_pkg::ADDR_CH_CTRL_MAIN);
  assign wr_ch_arm = i_reg_wr && (i_reg_addr == tdcd_pkg::ADDR_CH_CTRL_ARM);
  assign wr_cen_main = i_reg_wr && (i_reg_addr == tdcd_pkg::ADDR_CENTRAL_CTRL_MAIN);
  assign wr_cen_aux = i_reg_wr && (i_reg_addr == tdcd_pkg::ADDR_CENTRAL_CTRL_AUX);
  assign soft_reset = wr_cen_main && i_reg_wdata[tdcd_pkg::CEN_RESET_BIT];

  assign arm_sel = state_q.ctrl_arm[tdcd_pkg::CH_ARM_SEL_LSB +: 4];
  assign holdoff_code = state_q.ctrl_main[tdcd_pkg::CH_HOLDOFF_LSB +: 3];
  assign quiet = state_q.central_aux[tdcd_pkg::CEN_QUIET_BIT];

  // Edge of the chosen polarity on the event input
  assign edge_seen = state_q.ctrl_main[tdcd_pkg::CH_POL_BIT] ? (state_q.event_prev && !i_event)
                                                             : (!state_q.event_prev && i_event);
  assign armed = !state_q.ctrl_arm[tdcd_pkg::CH_ARM_EN_BIT] || i_arm_conditions[arm_sel];
  assign accept = edge_seen
                  && state_q.ctrl_main[tdcd_pkg::CH_POWER_BIT]
                  && state_q.ctrl_main[tdcd_pkg::CH_GATE_BIT]
                  && armed
                  && (state_q.holdoff_count == '0)
                  && !(quiet && (state_q.quiet_count == 5'(tdcd_pkg::QUIET_MAX_STAMPS)))
                  && !soft_reset;
  // Full queue refuses the push inside the queue; the stamp is lost
  assign q_push = accept;
  assign q_pop = i_reg_rd && (i_reg_addr == tdcd_pkg::ADDR_CH_STAMP_LOW) && !q_empty;

  tdcd_stamp_queue #(
    .WIDTH(SW),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flush(soft_reset),
    .i_push(q_push),
    .i_data(state_q.time_base),
    .i_pop(q_pop),
    .o_head(q_head),
    .o_full(q_full),
    .o_empty(q_empty)
  );

  tdcd_ready_timer #(
    .SETTLE_CYCLES(READY_SETTLE_CYCLES)
  ) u_ready (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(soft_reset),
    .o_done(settled)
  );

  always_comb
  begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    state_d.stamp_taken = 1'b0;
    state_d.time_base = state_q.time_base + 1'b1;
    state_d.event_prev = i_event;

    if (state_q.holdoff_count != '0)
    begin
      state_d.holdoff_count = state_q.holdoff_count - 1'b1;
    end
    if (accept)
    begin
      state_d.stamp_taken = 1'b1;
      if (state_q.ctrl_main[tdcd_pkg::CH_HOLDOFF_TIME_EN_BIT])
      begin
        state_d.holdoff_count = 24'(state_q.holdoff_delay) << holdoff_code;
      end
      if (quiet)
      begin
        state_d.quiet_count = state_q.quiet_count + 1'b1;
      end
    end
    if (!quiet)
    begin
      state_d.quiet_count = '0;
    end

    // Register writes
    if (wr_ch_main)
    begin
      state_d.ctrl_main = i_reg_wdata & tdcd_pkg::CH_CTRL_MAIN_WMASK;
    end
    if (wr_ch_arm)
    begin
      state_d.ctrl_arm = i_reg_wdata & tdcd_pkg::CH_CTRL_ARM_WMASK;
    end
    if (i_reg_wr && (i_reg_addr == tdcd_pkg::ADDR_CH_HOLDOFF))
    begin
      state_d.holdoff_delay = i_reg_wdata;
    end
    if (i_reg_wr && (i_reg_addr[7:2] == tdcd_pkg::ADDR_CH_CAL_RR[7:2]))
    begin
      state_d.cal[i_reg_addr[1:0]] = i_reg_wdata;
    end
    if (wr_cen_main)
    begin
      state_d.central_main = i_reg_wdata & tdcd_pkg::CEN_CTRL_MAIN_WMASK;
    end
    if (wr_cen_aux)
    begin
      state_d.central_aux = i_reg_wdata & tdcd_pkg::CEN_CTRL_AUX_WMASK;
    end

    // Alarm: a new overheat in the clearing cycle keeps the flag set
    if (wr_cen_main && i_reg_wdata[tdcd_pkg::CEN_OT_CLR_BIT])
    begin
      state_d.overheat = 1'b0;
    end
    if (state_q.central_main[tdcd_pkg::CEN_OT_EN_BIT] && i_overheat)
    begin
      state_d.overheat = 1'b1;
    end

    // Status words track live state one cycle late
    state_d.ch_status = tdcd_pkg::REG_RESET;
    state_d.ch_status[tdcd_pkg::CH_ST_DLL_UNLOCK_BIT] = !i_dll_locked;
    state_d.ch_status[tdcd_pkg::CH_ST_FULL_BIT] = q_full;
    state_d.ch_status[tdcd_pkg::CH_ST_EMPTY_BIT] = q_empty;
    state_d.central_status = tdcd_pkg::REG_RESET;
    state_d.central_status[tdcd_pkg::CEN_ST_READY_BIT] = settled && i_core_clock_locked
                                                         && i_sync_dll_locked;
    state_d.central_status[tdcd_pkg::CEN_ST_OT_BIT] = state_q.overheat;
    state_d.central_status[tdcd_pkg::CEN_ST_SYNC_UNLOCK_BIT] = !i_sync_dll_locked;
    state_d.central_status[tdcd_pkg::CEN_ST_CLK_UNLOCK_BIT] = !i_core_clock_locked;

    // Result clock runs when enabled and halts whenever quiet mode is set
    state_d.result_clock_run = state_d.central_main[tdcd_pkg::CEN_RCLK_EN_BIT]
                               && !state_d.central_aux[tdcd_pkg::CEN_QUIET_BIT];

    // Register reads, answered one cycle after the strobe
    if (i_reg_rd)
    begin
      state_d.rvalid = 1'b1;
      unique case (i_reg_addr)
        tdcd_pkg::ADDR_CH_CTRL_MAIN: state_d.rdata = state_q.ctrl_main;
        tdcd_pkg::ADDR_CH_CTRL_ARM: state_d.rdata = state_q.ctrl_arm;
        tdcd_pkg::ADDR_CH_STATUS: state_d.rdata = state_q.ch_status;
        tdcd_pkg::ADDR_CH_HOLDOFF: state_d.rdata = state_q.holdoff_delay;
        tdcd_pkg::ADDR_CH_CAL_RR: state_d.rdata = state_q.cal[0];
        tdcd_pkg::ADDR_CH_CAL_RF: state_d.rdata = state_q.cal[1];
        tdcd_pkg::ADDR_CH_CAL_FR: state_d.rdata = state_q.cal[2];
        tdcd_pkg::ADDR_CH_CAL_FF: state_d.rdata = state_q.cal[3];
        tdcd_pkg::ADDR_CH_STAMP_LOW:
        begin
          // Low word read takes the oldest stamp and freezes it for mid and high
          if (!q_empty)
          begin
            state_d.snapshot = q_head;
            state_d.rdata = q_head[15:0];
          end
          else
          begin
            state_d.rdata = state_q.snapshot[15:0];
          end
        end
        tdcd_pkg::ADDR_CH_STAMP_MID: state_d.rdata = state_q.snapshot[31:16];
        tdcd_pkg::ADDR_CH_STAMP_HIGH: state_d.rdata = {8'h00, state_q.snapshot[39:32]};
        tdcd_pkg::ADDR_CENTRAL_CTRL_MAIN: state_d.rdata = state_q.central_main;
        tdcd_pkg::ADDR_CENTRAL_CTRL_AUX: state_d.rdata = state_q.central_aux;
        tdcd_pkg::ADDR_CENTRAL_STATUS: state_d.rdata = state_q.central_status;
        tdcd_pkg::ADDR_PART_ID: state_d.rdata = PART_ID;
        default: state_d.rdata = tdcd_pkg::REG_RESET;
      endcase
    end

    // Device reset clears every word; only the time base keeps running
    if (soft_reset)
    begin
      state_d = '0;
      state_d.time_base = state_q.time_base + 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_reg_rdata = state_q.rdata;
  assign o_reg_rvalid = state_q.rvalid;
  assign o_channel_power_enable = state_q.ctrl_main[tdcd_pkg::CH_POWER_BIT];
  assign o_holdoff_range_code = state_q.ctrl_main[tdcd_pkg::CH_HOLDOFF_LSB +: 3];
  assign o_precondition_enable = state_q.ctrl_main[tdcd_pkg::CH_PRECON_EN_BIT];
  assign o_ddr_mode = state_q.central_main[tdcd_pkg::CEN_DDR_BIT];
  assign o_result_clock_run = state_q.result_clock_run;
  assign o_result_clock_rate_select = state_q.central_main[tdcd_pkg::CEN_RCLK_SEL_LSB +: 2];
  assign o_result_word_length_select = state_q.central_main[tdcd_pkg::CEN_LENGTH_LSB +: 3];
  assign o_coarse_counter_range = state_q.central_aux[tdcd_pkg::CEN_CNT_RNG_LSB +: 2];
  assign o_unit_ready_flag = state_q.central_status[tdcd_pkg::CEN_ST_READY_BIT];
  assign o_overheat_alarm_flag = state_q.overheat;
  assign o_stamp_taken = state_q.stamp_taken;

endmodule : tdcd_regs
`default_nettype wire

// ==== tb/tdcd_regs_props.sv ====
// Bound checks on the channel D register block ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tdcd_regs_props #(
  parameter logic [15:0] PART_ID = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_event,
  input wire logic i_core_clock_locked,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_channel_power_enable,
  input wire logic [2:0] o_holdoff_range_code,
  input wire logic o_ddr_mode,
  input wire logic o_unit_ready_flag,
  input wire logic o_stamp_taken
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_ctrl_wr;
    i_reg_wr && i_reg_addr == 8'h60;
  endsequence
  sequence s_soft_rst;
    i_reg_wr && i_reg_addr == 8'h80 && i_reg_wdata[1];
  endsequence
  sequence s_cleared;
    !o_channel_power_enable && o_holdoff_range_code == 3'h0 && !o_ddr_mode ##0 !o_unit_ready_flag [*8];
  endsequence

  a_power_follow: assert property (s_ctrl_wr |=> o_channel_power_enable == $past(i_reg_wdata[0]))
    else $error("power enable does not follow control write");
  a_holdoff_code: assert property (s_ctrl_wr |=> o_holdoff_range_code == $past(i_reg_wdata[9:7]))
    else $error("hold-off range code does not follow control write");
  a_ddr_follow: assert property (i_reg_wr && i_reg_addr == 8'h80 && !i_reg_wdata[1]
    |=> o_ddr_mode == $past(i_reg_wdata[2])) else $error("double-rate mode does not follow write");
  a_soft_reset: assert property (s_soft_rst |=> s_cleared)
    else $error("soft reset did not clear the block");
  a_ready_start: assert property ($rose(i_rst_n) |-> !o_unit_ready_flag [*8])
    else $error("ready flag high too soon after reset");
  a_ready_lock: assert property (!i_core_clock_locked [*3] |-> !o_unit_ready_flag)
    else $error("ready flag high while clock unlocked");
  a_stamp_power: assert property (o_stamp_taken |-> $past(o_channel_power_enable))
    else $error("stamp taken while channel powered down");
  a_stamp_edge: assert property (o_stamp_taken |-> $past(i_event) != $past(i_event, 2))
    else $error("stamp taken without an event edge");
  a_read_answer: assert property (1'b1 |=> o_reg_rvalid == $past(i_reg_rd))
    else $error("read answer pulse wrong");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 8'h83 |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_id_word: assert property (i_reg_rd && i_reg_addr == 8'h83 |=> o_reg_rdata == PART_ID)
    else $error("identification word wrong");
  a_stamp_top: assert property (i_reg_rd && i_reg_addr == 8'h72 |=> o_reg_rdata[15:8] == 8'h00)
    else $error("stamp top byte not zero");
endmodule : tdcd_regs_props
`default_nettype wire

// ==== tb/tdcd_host.sv ====
// Host model on the strobed register port: word writes, reads and settle waits.
// Assumes a read is answered on the edge that takes the strobe and sampled half a cycle later.
`timescale 1ns/100ps
`default_nettype none
module tdcd_host #(
  parameter int ENABLE_SETTLE_CYCLES = 4000
) (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_ready,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
  endtask : rd
  // Channel must not be trusted before its enable has settled
  task automatic settle();
    repeat (ENABLE_SETTLE_CYCLES) @(negedge i_clk);
  endtask : settle
  // Bounded wait for the device to come up after a reset
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    repeat (200)
      if (!ok)
      begin
        @(negedge i_clk);
        ok = (i_ready === 1'b1);
      end
  endtask : wait_ready
endmodule : tdcd_host
`default_nettype wire

// ==== tb/tb.sv ====
// Bench for the channel D register block: table of register cases, then reset and event cases.
// Assumes tdcd_host drives the register port and tdcd_regs_props is bound to the block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [15:0] ID_VALUE = 16'h3c07; // Arbitrary value
  typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] e;} tdcd_row_t;
  tdcd_row_t rows [12] = '{'{8'h60, 16'hffff, 16'h2787}, '{8'h61, 16'hffff, 16'h003e},
    '{8'h66, 16'hffff, 16'hffff}, '{8'h6c, 16'ha5a5, 16'ha5a5}, '{8'h6d, 16'h5a5a, 16'h5a5a},
    '{8'h6e, 16'h1234, 16'h1234}, '{8'h6f, 16'hfedc, 16'hfedc}, '{8'h80, 16'hf7fd, 16'hf7fd},
    '{8'h81, 16'hffff, 16'h000e}, '{8'h64, 16'hffff, 16'h0010}, '{8'h83, 16'hffff, ID_VALUE},
    '{8'h90, 16'hffff, 16'h0000}};
  logic i_clk, i_rst_n, i_event, i_dll_locked, i_core_clock_locked, i_reg_wr, i_reg_rd, ok, i_overheat;
  logic i_sync_dll_locked;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, i_arm_conditions, o_reg_rdata, lo, mid, hi;
  logic o_reg_rvalid, o_channel_power_enable, o_precondition_enable, o_ddr_mode, o_result_clock_run;
  logic o_unit_ready_flag, o_overheat_alarm_flag, o_stamp_taken;
  logic [2:0] o_holdoff_range_code, o_result_word_length_select;
  logic [1:0] o_result_clock_rate_select, o_coarse_counter_range;
  logic [13:0] outs;
  logic [39:0] st, prev;
  int n_errors = 0;
  int checks_done = 0;
  int n_stamps = 0;
  int i;

  tdcd_regs #(.READY_SETTLE_CYCLES(20), .PART_ID(ID_VALUE)) u_dut (
    .i_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .i_event, .i_arm_conditions,
    .i_dll_locked, .i_sync_dll_locked, .i_core_clock_locked, .i_overheat, .o_reg_rdata,
    .o_reg_rvalid, .o_channel_power_enable, .o_holdoff_range_code, .o_precondition_enable, .o_ddr_mode,
    .o_result_clock_run, .o_result_clock_rate_select, .o_result_word_length_select, .o_coarse_counter_range,
    .o_unit_ready_flag, .o_overheat_alarm_flag, .o_stamp_taken
  );
  tdcd_host u_host (
    .i_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .i_ready(o_unit_ready_flag),
    .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (o_stamp_taken === 1'b1)
      n_stamps <= n_stamps + 1;

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(string name, logic [39:0] seen, logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rchk(string name, logic [7:0] a, logic [15:0] e);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(name, 40'(d), 40'(e));
  endtask : rchk
  // Toggles the event line every two cycles, then counts the stamps taken
  task automatic stamps(int n, int e, string name);
    int c0;
    c0 = n_stamps;
    repeat (n)
    begin
      i_event = ~i_event;
      repeat (2) @(negedge i_clk);
    end
    repeat (2) @(negedge i_clk);
    chk(name, 40'(n_stamps - c0), 40'(e));
  endtask : stamps

  initial
  begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    i_rst_n = 1'b0;
    i_event = 1'b0;
    i_dll_locked = 1'b1;
    i_core_clock_locked = 1'b1;
    i_arm_conditions = 16'h0000;
    i_overheat = 1'b0;
    i_sync_dll_locked = 1'b1;
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    u_host.wait_ready(ok);
    chk("ready", 40'(ok), 40'h00_0000_0001);
    foreach (rows[i])
    begin
      u_host.wr(rows[i].a, rows[i].w);
      rchk("row", rows[i].a, rows[i].e);
    end
    outs = {o_channel_power_enable, o_holdoff_range_code, o_precondition_enable, o_ddr_mode, o_result_clock_run,
      o_result_clock_rate_select, o_result_word_length_select, o_coarse_counter_range};
    chk("outputs", 40'(outs), 40'h00_0000_3f7f);
    i_overheat = 1'b1;
    u_host.wr(8'h81, 16'h0000);
    chk("clock run", 40'({o_result_clock_run, o_coarse_counter_range}), 40'h00_0000_0004);
    u_host.wr(8'h80, 16'h0c00);
    chk("alarm kept", 40'(o_overheat_alarm_flag), 40'h00_0000_0001);
    u_host.wr(8'h80, 16'h0002);
    outs = {o_channel_power_enable, o_holdoff_range_code, o_precondition_enable, o_ddr_mode, 8'h00};
    chk("cleared", 40'({outs, o_unit_ready_flag, o_overheat_alarm_flag}), 40'h00_0000_0000);
    rchk("central status", 8'h82, 16'h0000);
    foreach (rows[i])
      rchk("reset value", rows[i].a, rows[i].a == 8'h83 ? ID_VALUE : rows[i].a == 8'h64 ? 16'h0010 : 16'h0000);
    for (i = 0; i < 3; i++)
      rchk("stamp reset", 8'h70 + 8'(i), 16'h0000);
    u_host.wait_ready(ok);
    chk("ready again", 40'(ok), 40'h00_0000_0001);
    i_core_clock_locked = 1'b0;
    repeat (3) @(negedge i_clk);
    rchk("clock unlock", 8'h82, 16'h0008);
    i_core_clock_locked = 1'b1;
    i_dll_locked = 1'b0;
    rchk("loop unlock", 8'h64, 16'h0011);
    i_dll_locked = 1'b1;
    i_sync_dll_locked = 1'b0;
    rchk("sync unlock", 8'h82, 16'h0004);
    i_sync_dll_locked = 1'b1;
    u_host.wait_ready(ok);
    u_host.wr(8'h60, 16'h0001);
    u_host.settle();
    stamps(4, 0, "gate closed");
    u_host.wr(8'h60, 16'h0002);
    stamps(4, 0, "powered down");
    u_host.wr(8'h60, 16'h0003);
    stamps(1, 1, "rising edge");
    u_host.wr(8'h60, 16'h0007);
    stamps(1, 1, "falling edge");
    stamps(1, 0, "rising ignored");
    u_host.wr(8'h60, 16'h0003);
    for (i = 0; i < 16; i++)
    begin
      u_host.wr(8'h61, 16'h0020 | 16'(i << 1));
      i_arm_conditions = 16'h0001 << i;
      stamps(2, 1, "arm met");
      i_arm_conditions = ~i_arm_conditions;
      stamps(2, 0, "arm unmet");
    end
    u_host.wr(8'h61, 16'h001e);
    i_arm_conditions = 16'h0000;
    stamps(2, 1, "arm off");
    u_host.wr(8'h66, 16'h0010);
    u_host.wr(8'h60, 16'h0483);
    stamps(12, 1, "hold-off");
    u_host.wr(8'h80, 16'h0002);
    u_host.wr(8'h60, 16'h0003);
    stamps(40, 20, "fill");
    rchk("full", 8'h64, 16'h0008);
    for (i = 0; i < 16; i++)
    begin
      u_host.rd(8'h70, lo);
      u_host.rd(8'h71, mid);
      u_host.rd(8'h72, hi);
      chk("stamp top", 40'(hi[15:8]), 40'h00_0000_0000);
      st = {hi[7:0], mid, lo};
      if (i > 0)
        chk("stamp step", st - prev, 40'h00_0000_0004);
      prev = st;
    end
    rchk("drained", 8'h64, 16'h0010);
    u_host.wr(8'h80, 16'h0002);
    u_host.wr(8'h60, 16'h0003);
    u_host.wr(8'h81, 16'h0008);
    stamps(40, 16, "quiet");
    report_and_stop();
  end
endmodule : tb

bind tdcd_regs tdcd_regs_props #(.PART_ID(PART_ID)) u_props (
  .i_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .i_event, .i_core_clock_locked,
  .o_reg_rdata, .o_reg_rvalid, .o_channel_power_enable, .o_holdoff_range_code, .o_ddr_mode,
  .o_unit_ready_flag, .o_stamp_taken
);
`default_nettype wire
